//--- bil_pkg.sv
/*
 * Shared constants and types of the boot image loader: timing counts,
 * SPI command, CRC constants, boot source codes, PLL presets, states.
 * Assumes a 40 MHz system clock.
 */
package bil_pkg;
    localparam int CLK_HZ         = 40_000_000;
    localparam int RST_PHASE_US   = 15;
    localparam int RST_PHASE_CYC  = (RST_PHASE_US * (CLK_HZ / 1_000_000));
    localparam int LINK_EN_NS     = 200;
    localparam int LINK_EN_CYC    = (LINK_EN_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int SPI_DIV        = 160;
    localparam int CMD_BITS       = 32;
    localparam int LOAD_BASE      = 0;
    localparam int OTP_BASE       = 0;
    localparam int SEC_BOOT_BIT   = 5;

    localparam logic [7:0]  SPI_READ_OP = 8'h03;
    localparam logic [23:0] SPI_ADDR    = 24'h000000;
    localparam logic [31:0] CRC_POLY    = 32'hedb88320;
    localparam logic [31:0] CRC_INIT    = 32'hffffffff;
    localparam logic [31:0] CRC_BYPASS  = 32'h0d15ab1e;
    localparam logic [31:0] NULL_CHAN   = 32'h0000ff02;
    localparam logic [7:0]  END_TOKEN   = 8'h01;

    localparam logic [1:0] SRC_TEST = 2'h0;
    localparam logic [1:0] SRC_RSVD = 2'h1;
    localparam logic [1:0] SRC_LINK = 2'h2;
    localparam logic [1:0] SRC_SPI  = 2'h3;

    localparam logic [1:0] PH_LEN  = 2'h0;
    localparam logic [1:0] PH_PROG = 2'h1;
    localparam logic [1:0] PH_CHK  = 2'h2;

    // {output divider[2:0], feedback multiplier[11:0], reference divider[5:0]}
    localparam logic [20:0] PLL_SET_00 = {3'h1, 12'd122, 6'h0};
    localparam logic [20:0] PLL_SET_01 = {3'h2, 12'd23, 6'h0};
    localparam logic [20:0] PLL_SET_10 = {3'h2, 12'd49, 6'h0};
    localparam logic [20:0] PLL_SET_11 = {3'h2, 12'd119, 6'h0};

    typedef enum logic [9:0] {
        ST_RESET     = 10'h001,
        ST_START     = 10'h002,
        ST_LINK_EN   = 10'h004,
        ST_LINK_ACK  = 10'h008,
        ST_LOAD      = 10'h010,
        ST_LINK_END  = 10'h020,
        ST_LINK_TX   = 10'h040,
        ST_RUN       = 10'h080,
        ST_HALT      = 10'h100,
        ST_WAIT_TEST = 10'h200
    } bil_state_t;
endpackage

//--- bil_boot_loader.sv
/*
 * Boot image loader: reset phase, strap decode, SPI / link / OTP image
 * fetch, CRC-32 check, RAM fill and jump.
 * Assumes a single 40 MHz clock, a synchronous active-low reset, a link
 * layer that hands over bytes and control tokens on this clock, and an
 * OTP and RAM port on this clock.
 */
`timescale 1ns/1ps
module bil_boot_loader
    import bil_pkg::*;
#(
    parameter int RAM_AW = 14,
    parameter int OTP_AW = 11
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [1:0]        boot_src_strap,
    input  wire logic              clock_ratio_strap_lo,
    input  wire logic              clock_ratio_strap_hi,
    input  wire logic [31:0]       security_reg,
    output logic                   gpio_pull_en,
    output logic [2:0]             pll_output_divider,
    output logic [11:0]            pll_feedback_mult,
    output logic [5:0]             pll_ref_divider,
    input  wire logic              spi_miso,
    output logic                   spi_ss_n,
    output logic                   spi_sclk,
    output logic                   spi_mosi,
    output logic                   spi_oe,
    output logic                   link_out_wire_a,
    output logic                   link_out_wire_b,
    output logic                   link_out_oe,
    output logic                   link_pulldown_en,
    input  wire logic              link_in_wire_a,
    input  wire logic              link_in_wire_b,
    output logic                   link_traffic,
    input  wire logic              link_rx_valid,
    input  wire logic              link_rx_ctrl,
    input  wire logic [7:0]        link_rx_data,
    output logic                   link_rx_ready,
    output logic                   link_tx_valid,
    output logic                   link_tx_ctrl,
    output logic [7:0]             link_tx_data,
    input  wire logic              link_tx_ready,
    output logic                   chan0_alloc,
    output logic [31:0]            ack_chan,
    output logic                   otp_rd,
    output logic [OTP_AW-1:0]      otp_addr,
    input  wire logic [31:0]       otp_rdata,
    input  wire logic              otp_rvalid,
    output logic                   ram_we,
    output logic [RAM_AW-1:0]      ram_addr,
    output logic [31:0]            ram_wdata,
    output logic                   boot_wait_test,
    output logic                   exec_start,
    output logic [RAM_AW-1:0]      exec_addr,
    output logic                   boot_error
);
    typedef struct packed {
        bil_state_t          st;
        logic [15:0]         tmr;
        logic [1:0]          src_m;
        logic [1:0]          src_s;
        logic [1:0]          rat_m;
        logic [1:0]          rat_s;
        logic [2:0]          in_m;
        logic [2:0]          in_s;
        logic [1:0]          src;
        logic                secure;
        logic [20:0]         pll;
        logic                pull_en;
        logic                spi_pins;
        logic                spi_on;
        logic                ss_n;
        logic                sclk;
        logic [7:0]          div;
        logic [31:0]         sreg;
        logic [5:0]          txb;
        logic [2:0]          rxb_n;
        logic [7:0]          rxb;
        logic                rx_stb;
        logic                link_on;
        logic                traffic;
        logic [1:0]          phase;
        logic [31:0]         cnt;
        logic [31:0]         len;
        logic [31:0]         word;
        logic [31:0]         crc;
        logic                ram_we;
        logic [RAM_AW-1:0]   ram_addr;
        logic [31:0]         ram_wdata;
        logic [31:0]         ack_chan;
        logic                chan0;
        logic                tx_valid;
        logic                otp_rd;
        logic                otp_pend;
        logic [2:0]          otp_left;
        logic [31:0]         otp_word;
        logic [OTP_AW-1:0]   otp_addr;
        logic                run;
        logic                err;
    } bil_regs_t;

    bil_regs_t   r;
    bil_regs_t   next_r;
    logic        in_ok;
    logic [7:0]  in_b;
    logic [31:0] nw;
    logic        fin;

    // one byte through the reflected CRC-32
    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] x;
        x = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] idx,
                                             input logic [7:0] b);
        logic [31:0] y;
        y = w;
        y[8*idx +: 8] = b;
        return y;
    endfunction

    function automatic logic [20:0] pll_preset(input logic [1:0] s);
        logic [20:0] p;
        case (s)
            2'h0:    p = PLL_SET_00;
            2'h1:    p = PLL_SET_01;
            2'h2:    p = PLL_SET_10;
            default: p = PLL_SET_11;
        endcase
        return p;
    endfunction

    always_comb begin
        next_r = r;
        next_r.ram_we = 1'h0;
        next_r.rx_stb = 1'h0;
        next_r.otp_rd = 1'h0;
        next_r.src_m = boot_src_strap;
        next_r.src_s = r.src_m;
        next_r.rat_m = {clock_ratio_strap_hi, clock_ratio_strap_lo};
        next_r.rat_s = r.rat_m;
        next_r.in_m = {link_in_wire_b, link_in_wire_a, spi_miso};
        next_r.in_s = r.in_m;
        fin = 1'h0;
        if (r.secure) begin
            in_ok = (r.otp_left != 3'h0);
            in_b = r.otp_word[7:0];
        end else if (r.src == SRC_SPI) begin
            in_ok = r.rx_stb;
            in_b = r.rxb;
        end else begin
            in_ok = link_rx_valid && !link_rx_ctrl;
            in_b = link_rx_data;
        end
        nw = put_byte(r.word, r.cnt[1:0], in_b);

        // SPI engine: mode 0, command MSB first, data LSB first
        if (r.spi_on) begin
            next_r.div = r.div + 8'h01;
            if (r.div == 8'(SPI_DIV / 2 - 1)) begin
                next_r.div = 8'h00;
                next_r.sclk = !r.sclk;
                if (!r.sclk) begin
                    if (r.txb != 6'(CMD_BITS)) begin
                        next_r.txb = r.txb + 6'h01;
                    end else begin
                        next_r.rxb = {r.in_s[0], r.rxb[7:1]};
                        next_r.rxb_n = r.rxb_n + 3'h1;
                        next_r.rx_stb = (r.rxb_n == 3'h7);
                    end
                end else begin
                    next_r.sreg = {r.sreg[30:0], 1'h0};
                end
            end
        end

        // OTP word reader feeding bytes low first
        if (r.secure && r.st == ST_LOAD) begin
            if (r.otp_left != 3'h0) begin
                next_r.otp_word = {8'h00, r.otp_word[31:8]};
                next_r.otp_left = r.otp_left - 3'h1;
            end else if (!r.otp_pend) begin
                next_r.otp_rd = 1'h1;
                next_r.otp_pend = 1'h1;
            end
            if (r.otp_pend && otp_rvalid) begin
                next_r.otp_word = otp_rdata;
                next_r.otp_left = 3'h4;
                next_r.otp_pend = 1'h0;
                next_r.otp_addr = r.otp_addr + OTP_AW'(1);
            end
        end

        if (r.link_on && (r.in_s[1] || r.in_s[2])) begin
            next_r.traffic = 1'h1;
        end

        case (r.st)
            ST_RESET: begin
                next_r.tmr = r.tmr + 16'h0001;
                if (r.tmr == 16'(RST_PHASE_CYC - 1)) begin
                    next_r.tmr = 16'h0000;
                    next_r.pull_en = 1'h1;
                    next_r.pll = pll_preset(r.rat_s);
                    next_r.src = r.src_s;
                    next_r.secure = security_reg[SEC_BOOT_BIT];
                    next_r.crc = CRC_INIT;
                    next_r.st = ST_START;
                end
            end
            ST_START: begin
                if (r.secure) begin
                    next_r.otp_addr = OTP_AW'(OTP_BASE);
                    next_r.st = ST_LOAD;
                end else if (r.src == SRC_SPI) begin
                    next_r.spi_pins = 1'h1;
                    next_r.spi_on = 1'h1;
                    next_r.ss_n = 1'h0;
                    next_r.sreg = {SPI_READ_OP, SPI_ADDR};
                    next_r.st = ST_LOAD;
                end else if (r.src == SRC_LINK) begin
                    next_r.tmr = 16'h0001;
                    next_r.st = ST_LINK_EN;
                end else begin
                    next_r.st = ST_WAIT_TEST;
                end
            end
            ST_LINK_EN: begin
                next_r.tmr = r.tmr + 16'h0001;
                if (r.tmr >= 16'(LINK_EN_CYC - 1)) begin
                    next_r.link_on = 1'h1;
                    next_r.chan0 = 1'h1;
                    next_r.st = ST_LINK_ACK;
                end
            end
            ST_LINK_ACK: begin
                if (in_ok) begin
                    next_r.word = nw;
                    next_r.cnt = r.cnt + 32'h1;
                    if (r.cnt[1:0] == 2'h3) begin
                        next_r.ack_chan = nw;
                        next_r.cnt = 32'h0;
                        next_r.st = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                if (in_ok) begin
                    next_r.word = nw;
                    next_r.cnt = r.cnt + 32'h1;
                    case (r.phase)
                        PH_LEN: begin
                            next_r.crc = crc8(r.crc, in_b);
                            if (r.cnt[1:0] == 2'h3) begin
                                next_r.len = nw;
                                next_r.cnt = 32'h0;
                                next_r.phase = (nw == 32'h0) ? PH_CHK : PH_PROG;
                            end
                        end
                        PH_PROG: begin
                            next_r.crc = crc8(r.crc, in_b);
                            if (r.cnt[1:0] == 2'h3) begin
                                next_r.ram_we = 1'h1;
                                next_r.ram_addr = r.cnt[RAM_AW+1:2];
                                next_r.ram_wdata = nw;
                            end
                            if (next_r.cnt == {r.len[29:0], 2'h0}) begin
                                next_r.cnt = 32'h0;
                                next_r.phase = PH_CHK;
                            end
                        end
                        default: begin
                            fin = (r.cnt[1:0] == 2'h3);
                        end
                    endcase
                    if (fin) begin
                        next_r.spi_on = 1'h0;
                        next_r.ss_n = 1'h1;
                        next_r.sclk = 1'h0;
                        if (nw != CRC_BYPASS && nw != ~r.crc) begin
                            next_r.err = 1'h1;
                            next_r.st = ST_HALT;
                        end else if (r.link_on) begin
                            next_r.st = ST_LINK_END;
                        end else begin
                            next_r.run = 1'h1;
                            next_r.st = ST_RUN;
                        end
                    end
                end
            end
            ST_LINK_END: begin
                if (link_rx_valid && link_rx_ctrl && link_rx_data == END_TOKEN) begin
                    if (r.ack_chan == NULL_CHAN) begin
                        next_r.chan0 = 1'h0;
                        next_r.run = 1'h1;
                        next_r.st = ST_RUN;
                    end else begin
                        next_r.tx_valid = 1'h1;
                        next_r.st = ST_LINK_TX;
                    end
                end
            end
            ST_LINK_TX: begin
                if (link_tx_ready) begin
                    next_r.tx_valid = 1'h0;
                    next_r.chan0 = 1'h0;
                    next_r.run = 1'h1;
                    next_r.st = ST_RUN;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r <= '0;
            r.st <= ST_RESET;
            r.ss_n <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    assign gpio_pull_en       = r.pull_en;
    assign pll_output_divider = r.pll[20:18];
    assign pll_feedback_mult  = r.pll[17:6];
    assign pll_ref_divider    = r.pll[5:0];
    assign spi_ss_n           = r.ss_n;
    assign spi_sclk           = r.sclk;
    assign spi_mosi           = r.sreg[31];
    assign spi_oe             = r.spi_pins;
    assign link_out_wire_a    = 1'h0;
    assign link_out_wire_b    = 1'h0;
    assign link_out_oe        = r.link_on;
    assign link_pulldown_en   = r.pull_en && !r.link_on;
    assign link_traffic       = r.traffic;
    assign link_rx_ready      = r.link_on && (r.st inside {ST_LINK_ACK, ST_LOAD, ST_LINK_END});
    assign link_tx_valid      = r.tx_valid;
    assign link_tx_ctrl       = r.tx_valid;
    assign link_tx_data       = END_TOKEN;
    assign chan0_alloc        = r.chan0;
    assign ack_chan           = r.ack_chan;
    assign otp_rd             = r.otp_rd;
    assign otp_addr           = r.otp_addr;
    assign ram_we             = r.ram_we;
    assign ram_addr           = r.ram_addr;
    assign ram_wdata          = r.ram_wdata;
    assign boot_wait_test     = (r.st == ST_WAIT_TEST);
    assign exec_start         = r.run;
    assign exec_addr          = RAM_AW'(LOAD_BASE);
    assign boot_error         = r.err;

    default clocking bil_cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_HIZ_RESET: assert property (disable iff (1'b0)
        !rstn |=> !spi_oe && !link_out_oe && !gpio_pull_en)
        else $error("pin enabled during reset");
    AST_RESET_PHASE: assert property (
        $rose(gpio_pull_en) |-> $past(r.st == ST_RESET && r.tmr == 16'(RST_PHASE_CYC - 1)))
        else $error("pulls enabled at wrong time");
    AST_SRC_SPI: assert property (
        r.st == ST_START && !r.secure && r.src == SRC_SPI |=> !spi_ss_n && r.st == ST_LOAD)
        else $error("spi source not started");
    AST_SECURE: assert property (
        r.st == ST_START && r.secure |=> r.st == ST_LOAD && !r.spi_on && !r.link_on)
        else $error("secure boot not from otp");
    AST_BYPASS: assert property (
        fin && nw == CRC_BYPASS |=> r.st != ST_HALT && !boot_error)
        else $error("bypass word rejected");
    AST_CRC_FAIL: assert property (
        fin && nw != CRC_BYPASS && nw != ~r.crc |=> r.st == ST_HALT && boot_error && !exec_start)
        else $error("bad crc not halted");
    AST_SPI_DIV: assert property (
        $rose(spi_sclk) |-> ##79 (spi_sclk || !r.spi_on) ##1 (!spi_sclk || !r.spi_on))
        else $error("spi clock half period wrong");
    AST_CPOL0: assert property (
        spi_ss_n |-> !spi_sclk)
        else $error("spi clock not idle low");
    AST_LINK_EN: assert property (
        $rose(link_out_oe) |-> $past(r.st == ST_START, 8))
        else $error("link enable delay wrong");
    AST_LINK_WIRES: assert property (
        link_out_oe |-> !link_out_wire_a && !link_out_wire_b && !link_pulldown_en)
        else $error("link wires not in initial state");
    AST_END_TX: assert property (
        r.st == ST_LINK_TX && link_tx_ready |=> exec_start && !chan0_alloc && !link_tx_valid)
        else $error("end token handshake wrong");
endmodule // bil_boot_loader

//--- bil_spi_flash_model.sv
/* serial flash model holding a short bypass image read from address zero;
   assumes a mode 0 master that selects it once per boot */
`timescale 1ns/1ps
module bil_spi_flash_model (
    input  wire logic        spi_ss_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic [31:0]      cmd_seen
);
    logic [7:0] img [0:11] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'hc3, 8'h3c,
                               8'h1e, 8'hab, 8'h15, 8'h0d};
    int         bitn = 0;
    initial spi_miso = 1'b0;
    initial cmd_seen = 32'h0;
    always @(negedge spi_ss_n) bitn = 0;
    always @(posedge spi_sclk) begin
        if (!spi_ss_n) begin
            if (bitn < 32) cmd_seen <= {cmd_seen[30:0], spi_mosi};
            bitn = bitn + 1;
        end
    end
    // toggles when released, during the command or past the image, so a stale bit never passes
    always @(negedge spi_sclk or posedge spi_ss_n) begin
        if (spi_ss_n || bitn < 32 || bitn >= 128) spi_miso <= ~spi_miso;
        else spi_miso <= img[(bitn - 32) / 8][(bitn - 32) % 8];
    end
endmodule // bil_spi_flash_model

//--- bil_boot_loader_bench.sv
/* bench: strap decode, pll presets, spi, link and otp boots;
   assumes the flash model on the spi pins and a one-cycle otp */
`timescale 1ns/1ps
module bil_boot_loader_bench;
    import bil_pkg::*;
    logic        clk_sys = 1'b0, rstn = 1'b0, clock_ratio_strap_lo = 1'b0;
    logic        clock_ratio_strap_hi = 1'b0, link_in_wire_a = 1'b0, link_rx_valid = 1'b0;
    logic        link_rx_ctrl = 1'b0, otp_rvalid = 1'b0, link_in_wire_b = 1'b0;
    logic        link_tx_ready = 1'b0, link_tx_valid, link_tx_ctrl;
    logic [7:0]  link_tx_data;
    logic [1:0]  boot_src_strap = 2'h0;
    logic [7:0]  link_rx_data = 8'h00;
    logic [31:0] security_reg = 32'h0, otp_rdata = 32'h0, cmd_seen, last_w, crc, ack_chan, ack_w;
    logic        gpio_pull_en, spi_miso, spi_ss_n, spi_sclk, spi_mosi, spi_oe, link_out_oe;
    logic        link_out_wire_a, link_out_wire_b, link_pulldown_en, link_traffic, ram_we;
    logic        link_rx_ready, chan0_alloc, otp_rd, boot_wait_test, exec_start, boot_error;
    logic [2:0]  pll_output_divider;
    logic [11:0] pll_feedback_mult;
    logic [5:0]  pll_ref_divider;
    logic [10:0] otp_addr;
    logic [13:0] ram_addr, exec_addr, last_a;
    logic [31:0] ram_wdata;
    logic [31:0] otp_img [0:3] = '{32'h1, 32'hcafef00d, 32'h0bad0bad, 32'h0};
    logic [20:0] pll_tab [0:3] = '{PLL_SET_00, PLL_SET_01, PLL_SET_10, PLL_SET_11};
    logic [7:0]  img8 [0:7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h78, 8'h56, 8'h34, 8'h12};
    int          n_errors = 0, n_checks = 0, cyc = 0;
    longint      t0;

    bil_boot_loader dut (.clk_sys, .rstn, .boot_src_strap, .clock_ratio_strap_lo,
        .clock_ratio_strap_hi, .security_reg, .gpio_pull_en, .pll_output_divider,
        .pll_feedback_mult, .pll_ref_divider, .spi_miso, .spi_ss_n, .spi_sclk, .spi_mosi,
        .spi_oe, .link_out_wire_a, .link_out_wire_b, .link_out_oe, .link_pulldown_en,
        .link_in_wire_a, .link_in_wire_b, .link_traffic, .link_rx_valid, .link_rx_ctrl,
        .link_rx_data, .link_rx_ready, .link_tx_valid, .link_tx_ctrl, .link_tx_data,
        .link_tx_ready, .chan0_alloc, .ack_chan, .otp_rd, .otp_addr, .otp_rdata,
        .otp_rvalid, .ram_we, .ram_addr, .ram_wdata, .boot_wait_test, .exec_start,
        .exec_addr, .boot_error);
    bil_spi_flash_model flash (.spi_ss_n, .spi_sclk, .spi_mosi, .spi_miso, .cmd_seen);

    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        otp_rvalid <= otp_rd;
        otp_rdata <= otp_img[otp_addr[1:0]];
        if (ram_we) {last_a, last_w} <= {ram_addr, ram_wdata};
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic boot(input logic [1:0] src, input logic [1:0] ratio, input logic [31:0] sec);
        @(posedge clk_sys);
        rstn <= 1'b0;
        boot_src_strap <= src; // straps stay put across reset release
        {clock_ratio_strap_hi, clock_ratio_strap_lo} <= ratio;
        security_reg <= sec;
        repeat (8) @(posedge clk_sys);
        #1 check({gpio_pull_en, spi_oe, link_out_oe}, 32'h0);
        @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (RST_PHASE_CYC - 1) @(posedge clk_sys);
        #1 check(gpio_pull_en, 32'h0);
        repeat (6) @(posedge clk_sys);
        #1 check(gpio_pull_en, 32'h1);
        check({pll_output_divider, pll_feedback_mult, pll_ref_divider}, pll_tab[ratio]);
    endtask
    // holds valid across back-to-back bytes; caller drops it after the last
    task automatic send(input logic ctrl, input logic [7:0] data);
        logic ok;
        link_rx_valid <= 1'b1;
        link_rx_ctrl <= ctrl;
        link_rx_data <= data;
        do begin
            @(negedge clk_sys);
            ok = link_rx_ready;
            @(posedge clk_sys);
        end while (!ok);
    endtask
    function automatic logic [31:0] crc32(input logic [7:0] b [0:7]);
        logic [31:0] c = 32'hffffffff;
        foreach (b[i]) begin
            c ^= {24'h0, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
        end
        return ~c;
    endfunction

    initial begin
        boot(2'h0, 2'h0, 32'h0);
        check(boot_wait_test, 32'h1);
        boot(2'h1, 2'h1, 32'h0);
        check(boot_wait_test, 32'h1);
        boot(2'h3, 2'h3, 32'h0);
        check({spi_oe, spi_ss_n, spi_sclk}, 32'h4);
        @(posedge spi_sclk);
        t0 = $time;
        @(posedge spi_sclk);
        check(32'(($time - t0) / 25), 32'd160);
        while (!exec_start && !boot_error) @(negedge clk_sys);
        repeat (4) @(negedge clk_sys);
        check(cmd_seen, 32'h03000000);
        check({boot_error, exec_start, exec_addr}, {16'h0000, 2'b01, 14'h0000});
        check(last_w, 32'h3cc35aa5);
        check(last_a, 32'h0);
        check({spi_ss_n, spi_sclk}, 32'h2);
        // first pass with the null acknowledge channel, second with a real one
        for (int k = 0; k < 2; k++) begin
            ack_w = k ? 32'h00000105 : NULL_CHAN;
            boot(2'h2, 2'h2, 32'h0);
            check({link_out_oe, link_pulldown_en}, 32'h1);
            repeat (10) @(posedge clk_sys);
            #1 check({link_out_oe, link_pulldown_en}, 32'h2);
            check({link_out_wire_a, link_out_wire_b}, 32'h0);
            @(posedge clk_sys);
            link_in_wire_b <= 1'b1; // raised only once the link is enabled
            repeat (4) @(posedge clk_sys);
            #1 check(link_traffic, 32'h1);
            @(posedge clk_sys);
            link_in_wire_b <= 1'b0;
            crc = crc32(img8);
            for (int i = 0; i < 4; i++) send(1'b0, ack_w[8*i +: 8]);
            send(1'b1, 8'h55);
            for (int i = 0; i < 8; i++) send(1'b0, img8[i]);
            for (int i = 0; i < 4; i++) send(1'b0, crc[8*i +: 8]);
            send(1'b1, END_TOKEN);
            link_rx_valid <= 1'b0;
            repeat (3) @(posedge clk_sys);
            #1 check({link_tx_valid, link_tx_ctrl, link_tx_data}, k ? 32'h301 : 32'h001);
            check({exec_start, chan0_alloc}, k ? 32'h1 : 32'h2);
            @(posedge clk_sys);
            link_tx_ready <= 1'b1;
            @(posedge clk_sys);
            link_tx_ready <= 1'b0;
            while (!exec_start && !boot_error) @(negedge clk_sys);
            check({boot_error, exec_start, chan0_alloc}, 32'h2);
            check(ack_chan, ack_w);
            check(last_w, 32'h12345678);
        end
        boot(2'h3, 2'h0, 32'h20);
        @(posedge clk_sys);
        link_in_wire_a <= 1'b1;
        while (!exec_start && !boot_error) @(negedge clk_sys);
        check({boot_error, exec_start, spi_ss_n, spi_oe}, 32'ha);
        check(link_traffic, 32'h0);
        check(last_w, 32'hcafef00d);
        print_verdict;
    end
endmodule // bil_boot_loader_bench
